// ==== spm_defs.svh ====
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH
// Pin map: port A 0..3, port B 4..11, port C 12..19, serial tx 20, rx 21
`define SPM_NPINS      22
`define SPM_PA0        0
`define SPM_PB0        4
`define SPM_PB3        7
`define SPM_PB6        10
`define SPM_PB7        11
`define SPM_PC0        12
`define SPM_PC1        13
`define SPM_PC2        14
`define SPM_PC3        15
`define SPM_PC4        16
`define SPM_SCI_TX     20
`define SPM_SCI_RX     21
// Register byte offsets
`define SPM_OFF_FUNC   8'h00
`define SPM_OFF_DIR    8'h04
`define SPM_OFF_DATA   8'h08
`define SPM_OFF_IN     8'h0c
`define SPM_OFF_SACT   8'h10
`define SPM_OFF_SYS    8'h14
// Reset values
`define SPM_FUNC_POR   22'h00e000
`define SPM_FUNC_KEEP  22'h002000
`define SPM_SYS_RST    5'h08
// System control fields
`define SPM_SC_CLK_LO  0
`define SPM_SC_CLK_HI  1
`define SPM_SC_FLAG    2
`define SPM_SC_PDP_EN  3
`define SPM_SC_QUAD_EN 4
`define SPM_SC_W       5
`define SPM_SC_PDP_ST  8
`endif

// ==== spm_pkg.sv ====
package spm_pkg;
	// Simple action per compare pin, two bits each
	typedef enum logic [1:0] {
		SPM_FORCE_LOW,
		SPM_ACTIVE_LOW,
		SPM_ACTIVE_HIGH,
		SPM_FORCE_HIGH
	} spm_sact_type;
endpackage

// ==== spm_sync3.sv ====
`timescale 1ns/1ps
module spm_sync3 #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] level_r
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	if (WIDTH < 1) $error("spm_sync3: WIDTH must be positive");

	// Three stages; first stage feeds only the second
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			meta_r <= RST_VAL;
			s2_r   <= RST_VAL;
			s3_r   <= RST_VAL;
		end
		else
		begin
			meta_r <= async_in;
			s2_r   <= meta_r;
			s3_r   <= s2_r;
		end

	// A change is accepted once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_agree
			always_ff @(posedge clk or negedge resetn)
				if (!resetn)
					level_r[i] <= RST_VAL[i];
				else if (s2_r[i] == s3_r[i])
					level_r[i] <= s3_r[i];
		end
	endgenerate
endmodule // spm_sync3

// ==== spm_pin_cell.sv ====
`timescale 1ns/1ps
module spm_pin_cell (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic func_sel,
	input  wire logic func_drive,
	input  wire logic func_level,
	input  wire logic port_dir,
	input  wire logic port_data,
	output logic      pin_out_r,
	output logic      pin_oe_r
);
	logic oe_nxt;
	logic out_nxt;

	// Function mode follows the peripheral, port mode follows direction and data
	always_comb
	begin
		oe_nxt  = func_sel ? func_drive : port_dir;
		out_nxt = func_sel ? func_level : port_data;
	end

	// Driver off out of reset: pin starts as an input
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			pin_oe_r  <= 1'b0;
			pin_out_r <= 1'b0;
		end
		else
		begin
			pin_oe_r  <= oe_nxt;
			pin_out_r <= out_nxt;
		end
endmodule // spm_pin_cell

// ==== spm_shared_pin_mux.sv ====
// Notes on behaviour
// - Shared pins leave every reset as digital inputs with drivers off, unless noted.
// - Port A bits 0,1 feed converter one; bits 2,3 feed converter two.
// - Simple-compare pins in function mode follow compare result and simple action control.
// - Simple-compare pins float while unmasked power-drive-protect input is low.
// - Timer compare pins also float while unmasked power-drive-protect input is low.
// - Timer direction pin low counts up, high counts down.
// - One port B pin may carry an external clock to the timers.
// - One port C pin may carry the converter start trigger.
// - Capture pins one, two go to capture or quadrature; three, four capture only.
// - External flag pin drives a software-latched level.
// - Every reset leaves the external flag pin in flag output function.
// - Branch-condition input is sampled; branch taken when pin low.
// - Every reset leaves the branch-condition pin in its branch input function.
// - Power-on reset makes the clock pin drive clock chosen by source bits.
// - Serial transmit and receive pins each selectable as serial or port I/O.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "spm_defs.svh"
module spm_shared_pin_mux #(
	parameter int NUM_CLK_SRC = 4
) (
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   dev_reset,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic [`SPM_NPINS-1:0]  pin_in,
	output logic      [`SPM_NPINS-1:0]  pin_out,
	output logic      [`SPM_NPINS-1:0]  pin_oe,
	input  wire logic                   power_drive_protect_irq_n,
	input  wire logic [2:0]             simple_cmp_match,
	input  wire logic [2:0]             timer_cmp_level,
	input  wire logic [NUM_CLK_SRC-1:0] clk_src_level,
	input  wire logic                   sci_tx_level,
	output logic                        sci_rx_level,
	output logic      [1:0]             conv_one_analog_en,
	output logic      [1:0]             conv_two_analog_en,
	output logic                        timer_count_down,
	output logic                        timer_ext_clk,
	output logic                        conv_start_trigger,
	output logic      [3:0]             capture_level,
	output logic      [1:0]             quad_level,
	output logic                        branch_take
);
	localparam int NP = `SPM_NPINS;

	logic [NP-1:0]         func_r;
	logic [NP-1:0]         dir_r;
	logic [NP-1:0]         data_r;
	logic [5:0]            sact_r;
	logic [`SPM_SC_W-1:0]  sys_r;
	logic [NP-1:0]         sync_pin;
	logic                  pdp_level;
	logic                  pdp_active_r;
	logic [NP-1:0]         func_drive;
	logic [NP-1:0]         func_level;
	logic [2:0]            simple_level;
	logic [1:0]            clk_sel;
	logic                  clock_output_pin_r;
	logic                  addr_ok;
	logic                  wr_en;
	logic [31:0]           rd_nxt;

	if (NUM_CLK_SRC < 2 || NUM_CLK_SRC > 4)
		$error("spm_shared_pin_mux: NUM_CLK_SRC must be 2 to 4");

	// Pins and the protect input come from outside; protect idles high
	spm_sync3 #(
		.WIDTH   (NP + 1),
		.RST_VAL ({1'b1, {NP{1'b0}}})
	) u_sync (
		.clk      (clk),
		.resetn   (resetn),
		.async_in ({power_drive_protect_irq_n, pin_in}),
		.level_r  ({pdp_level, sync_pin})
	);

	// Protect is honoured only while unmasked
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			pdp_active_r <= 1'b0;
		else
			pdp_active_r <= sys_r[`SPM_SC_PDP_EN] & ~pdp_level;

	// Simple action: polarity or forced level per compare channel
	genvar c;
	generate
		for (c = 0; c < 3; c++)
		begin : g_sact
			spm_pkg::spm_sact_type mode;
			assign mode = spm_pkg::spm_sact_type'(sact_r[2*c+1:2*c]);
			always_comb
				unique case (mode)
					spm_pkg::SPM_FORCE_LOW:   simple_level[c] = 1'b0;
					spm_pkg::SPM_ACTIVE_LOW:  simple_level[c] = ~simple_cmp_match[c];
					spm_pkg::SPM_ACTIVE_HIGH: simple_level[c] = simple_cmp_match[c];
					spm_pkg::SPM_FORCE_HIGH:  simple_level[c] = 1'b1;
				endcase
		end
	endgenerate

	assign clk_sel = sys_r[`SPM_SC_CLK_HI:`SPM_SC_CLK_LO];

	// Selected clock source registered before reaching the pin
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			clock_output_pin_r <= 1'b0;
		else if (int'(clk_sel) < NUM_CLK_SRC)
			clock_output_pin_r <= clk_src_level[clk_sel];
		else
			clock_output_pin_r <= 1'b0;

	// Function-mode drive and level; input-only functions never drive
	always_comb
	begin
		func_drive = '0;
		func_level = '0;
		for (int i = 0; i < 3; i++)
		begin
			func_drive[`SPM_PB0 + i] = ~pdp_active_r;
			func_level[`SPM_PB0 + i] = simple_level[i];
			func_drive[`SPM_PB3 + i] = ~pdp_active_r;
			func_level[`SPM_PB3 + i] = timer_cmp_level[i];
		end
		func_drive[`SPM_PC1]    = 1'b1;
		func_level[`SPM_PC1]    = clock_output_pin_r;
		func_drive[`SPM_PC2]    = 1'b1;
		func_level[`SPM_PC2]    = sys_r[`SPM_SC_FLAG];
		func_drive[`SPM_SCI_TX] = 1'b1;
		func_level[`SPM_SCI_TX] = sci_tx_level;
	end

	// One cell per pin
	genvar p;
	generate
		for (p = 0; p < NP; p++)
		begin : g_pin
			spm_pin_cell u_cell (
				.clk        (clk),
				.resetn     (resetn),
				.func_sel   (func_r[p]),
				.func_drive (func_drive[p]),
				.func_level (func_level[p]),
				.port_dir   (dir_r[p]),
				.port_data  (data_r[p]),
				.pin_out_r  (pin_out[p]),
				.pin_oe_r   (pin_oe[p])
			);
		end
	endgenerate

	// Peripheral-facing levels; a pin in port mode gives its peripheral an idle level
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			conv_one_analog_en <= 2'h0;
			conv_two_analog_en <= 2'h0;
			timer_count_down   <= 1'b0;
			timer_ext_clk      <= 1'b0;
			conv_start_trigger <= 1'b0;
			capture_level      <= 4'h0;
			quad_level         <= 2'h0;
			branch_take        <= 1'b0;
			sci_rx_level       <= 1'b1;
		end
		else
		begin
			conv_one_analog_en <= func_r[`SPM_PA0+1:`SPM_PA0];
			conv_two_analog_en <= func_r[`SPM_PA0+3:`SPM_PA0+2];
			timer_count_down   <= func_r[`SPM_PB6] & sync_pin[`SPM_PB6];
			timer_ext_clk      <= func_r[`SPM_PB7] & sync_pin[`SPM_PB7];
			conv_start_trigger <= func_r[`SPM_PC0] & sync_pin[`SPM_PC0];
			for (int k = 0; k < 4; k++)
				capture_level[k] <= func_r[`SPM_PC4 + k] & sync_pin[`SPM_PC4 + k]
					& ~(sys_r[`SPM_SC_QUAD_EN] & (k < 2));
			for (int k = 0; k < 2; k++)
				quad_level[k] <= func_r[`SPM_PC4 + k] & sync_pin[`SPM_PC4 + k]
					& sys_r[`SPM_SC_QUAD_EN];
			branch_take        <= func_r[`SPM_PC3] & ~sync_pin[`SPM_PC3];
			sci_rx_level       <= ~func_r[`SPM_SCI_RX] | sync_pin[`SPM_SCI_RX];
		end

	// Bus decode; answer comes one cycle into the access phase
	always_comb
	begin
		addr_ok = 1'b1;
		rd_nxt  = 32'h0;
		unique case (paddr)
			`SPM_OFF_FUNC: rd_nxt[NP-1:0] = func_r;
			`SPM_OFF_DIR:  rd_nxt[NP-1:0] = dir_r;
			`SPM_OFF_DATA: rd_nxt[NP-1:0] = data_r;
			`SPM_OFF_IN:   rd_nxt[NP-1:0] = sync_pin;
			`SPM_OFF_SACT: rd_nxt[5:0]    = sact_r;
			`SPM_OFF_SYS:
			begin
				rd_nxt[`SPM_SC_W-1:0]  = sys_r;
				rd_nxt[`SPM_SC_PDP_ST] = pdp_active_r;
			end
			default:       addr_ok = 1'b0;
		endcase
	end

	assign wr_en = psel & penable & pready & pwrite & addr_ok;

	// Slave handshake
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end
		else if (psel && penable && !pready)
		begin
			pready  <= 1'b1;
			pslverr <= ~addr_ok;
			prdata  <= pwrite ? 32'h0 : rd_nxt;
		end
		else
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end

	// Function select; device reset keeps the current clock pin choice
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			func_r <= `SPM_FUNC_POR;
		else if (dev_reset)
			func_r <= (`SPM_FUNC_POR & ~`SPM_FUNC_KEEP) | (func_r & `SPM_FUNC_KEEP);
		else if (wr_en && paddr == `SPM_OFF_FUNC)
			func_r <= pwdata[NP-1:0];

	// Port direction and output data
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			dir_r  <= '0;
			data_r <= '0;
		end
		else if (dev_reset)
		begin
			dir_r  <= '0;
			data_r <= '0;
		end
		else
		begin
			if (wr_en && paddr == `SPM_OFF_DIR)
				dir_r <= pwdata[NP-1:0];
			if (wr_en && paddr == `SPM_OFF_DATA)
				data_r <= pwdata[NP-1:0];
		end

	// Action and system control; clock source survives a device reset
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			sact_r <= 6'h0;
			sys_r  <= `SPM_SYS_RST;
		end
		else if (dev_reset)
		begin
			sact_r <= 6'h0;
			sys_r  <= {(`SPM_SC_W - `SPM_SC_FLAG)'(`SPM_SYS_RST >> `SPM_SC_FLAG), sys_r[`SPM_SC_CLK_HI:`SPM_SC_CLK_LO]};
		end
		else
		begin
			if (wr_en && paddr == `SPM_OFF_SACT)
				sact_r <= pwdata[5:0];
			if (wr_en && paddr == `SPM_OFF_SYS)
				sys_r <= pwdata[`SPM_SC_W-1:0];
		end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_access_wait;
		psel && penable && !pready;
	endsequence

	sequence s_pdp_low;
		sys_r[`SPM_SC_PDP_EN] && !pdp_level;
	endsequence

	a_apb_answer: assert property (s_access_wait |=> pready ##1 !pready)
		else $error("answer not one cycle after access");

	a_reset_inputs: assert property (dev_reset |=> ##1 (pin_oe & ~`SPM_FUNC_POR) == '0)
		else $error("pin driven after device reset");

	a_flag_default: assert property (dev_reset |=> func_r[`SPM_PC2] && func_r[`SPM_PC3])
		else $error("flag or branch pin not in function after reset");

	a_simple_hiz: assert property (s_pdp_low ##1 func_r[`SPM_PB0] |=> !pin_oe[`SPM_PB0])
		else $error("simple compare pin driven under protect");

	a_timer_hiz: assert property (s_pdp_low ##1 func_r[`SPM_PB3 + 2] |=> !pin_oe[`SPM_PB3 + 2])
		else $error("timer compare pin driven under protect");

	a_port_kept: assert property (!func_r[`SPM_PB0] && dir_r[`SPM_PB0] |=> pin_oe[`SPM_PB0])
		else $error("port-mode pin lost its driver");

	a_simple_level: assert property (func_r[`SPM_PB0 + 1] && !pdp_active_r
		&& sact_r[3:2] == 2'h3 |=> pin_out[`SPM_PB0 + 1])
		else $error("forced-high compare pin not high");

	a_dir_follow: assert property (func_r[`SPM_PB6] |=> timer_count_down == $past(sync_pin[`SPM_PB6]))
		else $error("timer direction does not follow pin");

	a_branch_low: assert property (func_r[`SPM_PC3] && !sync_pin[`SPM_PC3] |=> branch_take)
		else $error("branch not taken on low pin");

	a_flag_level: assert property (func_r[`SPM_PC2] |=> pin_out[`SPM_PC2] == $past(sys_r[`SPM_SC_FLAG]))
		else $error("flag pin differs from latched level");

	// Peripheral routing follows function select and synchronised pad level one edge late; the clock pin lags its source two edges
	sequence s_clock_src0;
		func_r[`SPM_PC1] && clk_sel == 2'h0;
	endsequence

	a_clock_pin: assert property (s_clock_src0 ##1 func_r[`SPM_PC1]
		|=> pin_out[`SPM_PC1] == $past(clk_src_level[0], 2))
		else $error("clock pin differs from selected source");

	a_analog_route: assert property (1'b1 |=>
		{conv_two_analog_en, conv_one_analog_en} == $past(func_r[`SPM_PA0+3:`SPM_PA0]))
		else $error("analog enable differs from function select");

	a_ext_clock: assert property (func_r[`SPM_PB7] |=> timer_ext_clk == $past(sync_pin[`SPM_PB7]))
		else $error("timer clock does not follow pin");

	a_trigger_route: assert property (func_r[`SPM_PC0] |=> conv_start_trigger == $past(sync_pin[`SPM_PC0]))
		else $error("start trigger does not follow pin");

	a_quad_route: assert property (func_r[`SPM_PC4] && sys_r[`SPM_SC_QUAD_EN]
		|=> !capture_level[0] && quad_level[0] == $past(sync_pin[`SPM_PC4]))
		else $error("first capture pin not routed to quadrature");

	a_rx_idle: assert property (!func_r[`SPM_SCI_RX] |=> sci_rx_level)
		else $error("receive level not idle in port mode");
endmodule // spm_shared_pin_mux

// ==== spm_pad_model.sv ====
`timescale 1ns/1ps
`include "spm_defs.svh"
module spm_pad_model (
	input  wire logic                  clk,
	input  wire logic [`SPM_NPINS-1:0] pin_out,
	input  wire logic [`SPM_NPINS-1:0] pin_oe,
	input  wire logic [`SPM_NPINS-1:0] ext_level,
	input  wire logic [`SPM_NPINS-1:0] ext_en,
	output logic      [`SPM_NPINS-1:0] pin_in
);
	logic [`SPM_NPINS-1:0] last_r = '0;

	// Remember pad levels so a floating pad wanders instead of holding
	always_ff @(posedge clk)
		last_r <= pin_in;

	// Device driver wins, then the board; branch pad has a pull-up, others float
	always_comb
		for (int i = 0; i < `SPM_NPINS; i++)
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_level[i] : (i == `SPM_PC3) ? 1'h1 : ~last_r[i];
endmodule // spm_pad_model

// ==== spm_shared_pin_mux_test.sv ====
`timescale 1ns/1ps
`include "spm_defs.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; $display("mismatch %s exp %h got %h", n, e, g); end end
module spm_shared_pin_mux_test;
	logic        clk = 0, resetn = 0, dev_reset = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, er, q;
	logic [21:0] pin_in, pin_out, pin_oe, dir, dat, ext_level = '0, ext_en = 22'h3f7fff;
	logic        irq_n = 1, sci_tx = 0, sci_rx, down, ext_clk, soc, branch;
	logic [2:0]  smatch = '0, tlevel = '0;
	logic [3:0]  src = 4'ha, cap;
	logic [1:0]  an1, an2, quad;
	logic [5:0]  sact;
	int          mismatches = 0, samples_checked = 0, seed = 43625;

	// 100 MHz clock
	always #5 clk = ~clk;

	spm_shared_pin_mux #(.NUM_CLK_SRC(4)) u_spm_shared_pin_mux (.clk(clk), .resetn(resetn),
		.dev_reset(dev_reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .power_drive_protect_irq_n(irq_n), .simple_cmp_match(smatch),
		.timer_cmp_level(tlevel), .clk_src_level(src), .sci_tx_level(sci_tx), .sci_rx_level(sci_rx),
		.conv_one_analog_en(an1), .conv_two_analog_en(an2), .timer_count_down(down),
		.timer_ext_clk(ext_clk), .conv_start_trigger(soc), .capture_level(cap), .quad_level(quad),
		.branch_take(branch));

	spm_pad_model u_spm_pad_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.ext_level(ext_level), .ext_en(ext_en), .pin_in(pin_in));

	// Verdict and end of run
	task end_sim;
		if (mismatches == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// One APB transfer; the idle edge after it keeps two requests out of one time step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'h1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 16)
		begin
			mismatches++;
			end_sim();
		end
		@(posedge clk);
	endtask

	// Register read and compare
	task rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		`CHK("register", e, rd)
	endtask

	// Pad levels need several edges through the synchronisers
	task settle;
		repeat (8) @(posedge clk);
	endtask

	// Expected simple-compare pin level
	function logic act(input logic [1:0] m, input logic c);
		case (m)
			spm_pkg::SPM_FORCE_LOW: return 1'h0;
			spm_pkg::SPM_ACTIVE_LOW: return ~c;
			spm_pkg::SPM_ACTIVE_HIGH: return c;
			default: return 1'h1;
		endcase
	endfunction

	// Main sequence
	initial
	begin
		repeat (4) @(posedge clk);
		`CHK("oe_in_reset", 22'h0, pin_oe)
		resetn <= 1'h1;
		repeat (3) @(posedge clk);
		`CHK("oe_after_por", 22'h006000, pin_oe)
		rchk(`SPM_OFF_FUNC, 32'h0000e000);
		rchk(`SPM_OFF_DIR, 32'h0);
		rchk(`SPM_OFF_SYS, 32'h8);
		settle;
		`CHK("branch_pulled_up", 1'h0, branch)
		ext_en[15] <= 1'h1;
		settle;
		`CHK("branch_low", 1'h1, branch)
		apb(1'h0, 8'h18, 32'h0);
		`CHK("unmapped_err", 1'h1, er)
		`CHK("unmapped_data", 32'h0, rd)
		// Every clock source, flag toggling alongside
		for (int s = 0; s < 4; s++)
		begin
			apb(1'h1, `SPM_OFF_SYS, {28'h0, 1'h1, s[0], s[1:0]});
			settle;
			`CHK("clock_pin", src[s], pin_out[13])
			`CHK("flag_pin", s[0], pin_out[14])
		end
		// Port mode, random direction, data and pad levels
		repeat (4)
		begin
			dir = 22'($random(seed));
			dat = 22'($random(seed));
			ext_level <= 22'($random(seed));
			ext_en <= ~dir;
			apb(1'h1, `SPM_OFF_FUNC, 32'h0);
			apb(1'h1, `SPM_OFF_DIR, {10'h0, dir});
			apb(1'h1, `SPM_OFF_DATA, {10'h0, dat});
			settle;
			`CHK("port_oe", dir, pin_oe)
			`CHK("port_out", dat, pin_out)
			rchk(`SPM_OFF_IN, {10'h0, (dir & dat) | (~dir & ext_level)});
			`CHK("rx_idle", 1'h1, sci_rx)
			`CHK("dir_in_port", 1'h0, down)
		end
		// Function mode, rotating every simple action code over the three pins
		for (int i = 0; i < 4; i++)
		begin
			sact = {i[1:0] + 2'h2, i[1:0] + 2'h1, i[1:0]};
			q = i[0];
			ext_level <= 22'($random(seed));
			ext_en <= ~22'h1063f0;
			smatch <= 3'($random(seed));
			tlevel <= 3'($random(seed));
			sci_tx <= 1'($random(seed));
			apb(1'h1, `SPM_OFF_DIR, 32'h0);
			apb(1'h1, `SPM_OFF_FUNC, 32'h003fffff);
			apb(1'h1, `SPM_OFF_SACT, {26'h0, sact});
			apb(1'h1, `SPM_OFF_SYS, {27'h0, q, 4'h8});
			settle;
			`CHK("func_oe", 22'h1063f0, pin_oe)
			for (int k = 0; k < 3; k++)
				`CHK("simple_pin", act(sact[2*k +: 2], smatch[k]), pin_out[4+k])
			`CHK("timer_pins", tlevel, pin_out[9:7])
			`CHK("tx_pin", sci_tx, pin_out[20])
			`CHK("analog_en", 4'hf, {an2, an1})
			`CHK("count_down", ext_level[10], down)
			`CHK("ext_clock", ext_level[11], ext_clk)
			`CHK("conv_start", ext_level[12], soc)
			`CHK("capture", {ext_level[19:18], q ? 2'h0 : ext_level[17:16]}, cap)
			`CHK("quadrature", q ? ext_level[17:16] : 2'h0, quad)
			`CHK("branch", ~ext_level[15], branch)
			`CHK("rx_level", ext_level[21], sci_rx)
		end
		// Protect input low; pin 4 sits in port mode and must keep driving
		apb(1'h1, `SPM_OFF_DIR, 32'h10);
		apb(1'h1, `SPM_OFF_FUNC, 32'h003fffef);
		irq_n <= 1'h0;
		settle;
		`CHK("protect_oe", 6'h01, pin_oe[9:4])
		rchk(`SPM_OFF_SYS, {23'h0, 1'h1, 3'h0, q, 4'h8});
		apb(1'h1, `SPM_OFF_SYS, 32'h0);
		settle;
		`CHK("masked_oe", 6'h3f, pin_oe[9:4])
		irq_n <= 1'h1;
		// Device reset keeps clock pin function and source
		apb(1'h1, `SPM_OFF_SYS, 32'ha);
		ext_en <= ~22'h006000;
		dev_reset <= 1'h1;
		@(posedge clk);
		dev_reset <= 1'h0;
		repeat (3) @(posedge clk);
		`CHK("oe_after_devrst", 22'h006000, pin_oe)
		rchk(`SPM_OFF_FUNC, 32'h0000e000);
		rchk(`SPM_OFF_SYS, 32'ha);
		end_sim();
	end
endmodule // spm_shared_pin_mux_test
